// ---- verilog/stw_master.sv ----
// Bus master end of the two-wire register port. Makes the serial
// clock from clk_sys by a divider: four quarters of QTR_CYC per bit.
// Assumes a single slave on the link and no clock stretching.
`timescale 1ns/10ps
`default_nettype none
module stw_master
   import stw_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   stw_if.master link,
   input wire logic cmd_go,
   input wire logic cmd_rd,
   input wire logic cmd_cur,
   input wire logic cmd_alt,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_len,
   input wire logic [7:0] wr_data,
   output logic wr_take,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic busy,
   output logic nack
);

   stw_mstate_t st;
   stw_kind_t kind;
   logic [1:0] ph;
   logic [6:0] qcnt;
   logic tick;
   logic [3:0] bitn;
   logic [7:0] tx;
   logic [7:0] rx;
   logic [7:0] left;
   logic ackb;
   logic rd_mode;
   logic alt;
   logic [15:0] addr;
   logic scl_oe_n;
   logic sda_oe_n;
   logic drive_bit;
   logic [1:0] sda_s;

   assign link.scl_m_o = 1'b0;
   assign link.sda_m_o = 1'b0;
   assign link.scl_m_oe_n = scl_oe_n;
   assign link.sda_m_oe_n = sda_oe_n;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sda_s <= 2'b11;
      end else begin
         sda_s <= {sda_s[0], link.sda};
      end
   end

   assign tick = (qcnt == QTR_LAST);

   always_ff @(posedge clk_sys) begin
      if (sys_rst || st == MS_IDLE || tick) begin
         qcnt <= 7'h00;
      end else begin
         qcnt <= qcnt + 7'h01;
      end
   end

   // Data bits MSB first; in the ack slot of a read, low means more
   always_comb begin
      if (bitn != ACK_SLOT) begin
         drive_bit = (kind == MK_RDATA) ? 1'b1 : tx[7];
      end else begin
         drive_bit = (kind == MK_RDATA) ? (left == 8'h01) : 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st <= MS_IDLE;
         kind <= MK_ADDRW;
         ph <= 2'b00;
         bitn <= 4'h0;
         tx <= 8'h00;
         rx <= 8'h00;
         left <= 8'h00;
         ackb <= 1'b1;
         rd_mode <= 1'b0;
         alt <= 1'b0;
         addr <= PTR_RST;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         busy <= 1'b0;
         nack <= 1'b0;
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         case (st)
            MS_IDLE: begin
               if (cmd_go) begin
                  busy <= 1'b1;
                  nack <= 1'b0;
                  st <= MS_START;
                  ph <= 2'b00;
                  rd_mode <= cmd_rd;
                  alt <= cmd_alt;
                  addr <= cmd_addr;
                  left <= cmd_len;
                  kind <= cmd_cur ? MK_ADDRR : MK_ADDRW;
                  tx <= {stw_slave_addr(cmd_alt),
                         (cmd_cur ? RW_READ : RW_WRITE)};
               end
            end
            MS_START: begin
               if (tick) begin
                  ph <= ph + 2'b01;
                  case (ph)
                     2'b00: sda_oe_n <= 1'b1;
                     2'b01: scl_oe_n <= 1'b1;
                     2'b10: sda_oe_n <= 1'b0;
                     default: begin
                        scl_oe_n <= 1'b0;
                        st <= MS_BIT;
                        bitn <= 4'h0;
                     end
                  endcase
               end
            end
            MS_STOP: begin
               if (tick) begin
                  ph <= ph + 2'b01;
                  case (ph)
                     2'b00: sda_oe_n <= 1'b0;
                     2'b01: scl_oe_n <= 1'b1;
                     2'b10: sda_oe_n <= 1'b1;
                     default: begin
                        st <= MS_IDLE;
                        busy <= 1'b0;
                     end
                  endcase
               end
            end
            default: begin
               if (tick) begin
                  ph <= ph + 2'b01;
                  case (ph)
                     2'b00: sda_oe_n <= drive_bit;
                     2'b01: scl_oe_n <= 1'b1;
                     2'b10: begin
                        if (bitn == ACK_SLOT) begin
                           ackb <= sda_s[1];
                        end else begin
                           rx <= {rx[6:0], sda_s[1]};
                        end
                     end
                     default: begin
                        scl_oe_n <= 1'b0;
                        if (bitn != ACK_SLOT) begin
                           bitn <= bitn + 4'h1;
                           tx <= {tx[6:0], 1'b0};
                        end else begin
                           bitn <= 4'h0;
                           if (kind != MK_RDATA && ackb) begin
                              nack <= 1'b1;
                              st <= MS_STOP;
                           end else begin
                              case (kind)
                                 MK_ADDRW: begin
                                    kind <= MK_AHI;
                                    tx <= addr[15:8];
                                 end
                                 MK_AHI: begin
                                    kind <= MK_ALO;
                                    tx <= addr[7:0];
                                 end
                                 MK_ALO: begin
                                    if (rd_mode) begin
                                       // Restart without stop
                                       kind <= MK_ADDRR;
                                       tx <= {stw_slave_addr(alt), RW_READ};
                                       st <= MS_START;
                                    end else begin
                                       kind <= MK_WDATA;
                                       tx <= wr_data;
                                       wr_take <= 1'b1;
                                    end
                                 end
                                 MK_ADDRR: begin
                                    kind <= MK_RDATA;
                                 end
                                 MK_WDATA: begin
                                    left <= left - 8'h01;
                                    if (left == 8'h01) begin
                                       st <= MS_STOP;
                                    end else begin
                                       tx <= wr_data;
                                       wr_take <= 1'b1;
                                    end
                                 end
                                 default: begin
                                    rd_data <= rx;
                                    rd_valid <= 1'b1;
                                    left <= left - 8'h01;
                                    if (left == 8'h01) begin
                                       st <= MS_STOP;
                                    end
                                 end
                              endcase
                           end
                        end
                     end
                  endcase
               end
            end
         endcase
      end
   end

endmodule // stw_master
`default_nettype wire

// ---- verilog/stw_pkg.sv ----
// Shared constants, types and helpers of the two-wire register port.
// Compiled first; both ends and the property checker rely on it.
package stw_pkg;

   // Seven-bit slave addresses (0x20/0x21 and 0x30/0x31 on the wire)
   localparam logic [6:0] DEV_ADDR_DEF = 7'h10;
   localparam logic [6:0] DEV_ADDR_ALT = 7'h18;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;

   // Bit index within a byte frame; slot 8 is the acknowledge
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [15:0] PTR_RST = 16'h0000;

   // One quarter bit covers the start hold time, the longest quarter
   localparam int SYS_CLK_NS = 50;
   localparam int T_HD_STA_NS = 4000;
   localparam int QTR_CYC = (T_HD_STA_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);

   typedef enum logic [2:0] {
      DS_IDLE = 3'b000,
      DS_ADDR = 3'b001,
      DS_AHI = 3'b011,
      DS_ALO = 3'b010,
      DS_WDATA = 3'b110,
      DS_RDATA = 3'b111
   } stw_dstate_t;

   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_START = 2'b01,
      MS_BIT = 2'b11,
      MS_STOP = 2'b10
   } stw_mstate_t;

   typedef enum logic [2:0] {
      MK_ADDRW = 3'b000,
      MK_AHI = 3'b001,
      MK_ALO = 3'b011,
      MK_WDATA = 3'b010,
      MK_ADDRR = 3'b110,
      MK_RDATA = 3'b111
   } stw_kind_t;

   function automatic logic [6:0] stw_slave_addr(input logic alt);
      return alt ? DEV_ADDR_ALT : DEV_ADDR_DEF;
   endfunction

endpackage

// ---- verilog/stw_if.sv ----
// Two-wire link between the bus master end and the sensor end.
// Both lines are open drain with a pull-up; the wire levels are
// resolved here from each end's output and active-low enable on sda, and from the master end's alone on scl.
`timescale 1ns/10ps
`default_nettype none
interface stw_if;
   logic scl_m_o;
   logic scl_m_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_d_o;
   logic sda_d_oe_n;
   logic scl;
   logic sda;

   // Pull-up wins unless an end drives its line
   assign scl = scl_m_oe_n ? 1'b1 : scl_m_o;
   assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_d_oe_n ? 1'b1 : sda_d_o);

   modport master (
      output scl_m_o,
      output scl_m_oe_n,
      output sda_m_o,
      output sda_m_oe_n,
      input scl,
      input sda
   );

   modport dev (
      output sda_d_o,
      output sda_d_oe_n,
      input scl,
      input sda
   );
endinterface
`default_nettype wire

// ---- verilog/stw_dev.sv ----
// Sensor end of the two-wire register port: link logic on the serial
// clock, register writes handed to clk_sys. Assumes rd_data follows
// rd_addr within one serial clock period, and a legal master.
// Summary of operation
// - Released line after byte means no-acknowledge.
// - Master opens with start, address, direction.
// - Acknowledge own slave address byte.
// - Acknowledge both register address bytes.
// - Acknowledge write data; master then stops.
// - Read follows dummy write and restart.
// - Pointer advances after every data byte.
// - Release line after master no-acknowledge.
// - Single read sequence ordered by master.
// - Read without address uses current pointer.
// - Keep sending bytes while master acknowledges.
// - Single write sequence ordered by master.
// - Further write bytes go to successive addresses.
// - Address 0x20, or 0x30 when selected.
// - Receiver pulls line low to acknowledge.
// - Start and stop only while clock high.
// - Eight bits per byte, MSB first.
`timescale 1ns/10ps
`default_nettype none
module stw_dev
   import stw_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   stw_if.dev link,
   input wire logic addr_sel_en,
   input wire logic addr_sel,
   output logic [15:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic reg_wr,
   output logic [15:0] reg_waddr,
   output logic [7:0] reg_wdata
);

   logic start_tgl;
   logic stop_tgl;
   logic start_seen;
   logic stop_seen;
   logic sda_smp;
   stw_dstate_t st;
   logic [3:0] bitn;
   logic [7:0] rx;
   logic [7:0] tx;
   logic [7:0] byte_in;
   logic sda_oe_n;
   logic [1:0] sel_s;
   logic [1:0] en_s;
   logic own_hit;
   logic wr_tgl;
   logic [15:0] wr_addr_l;
   logic [7:0] wr_data_l;
   logic [2:0] wr_s;

   // Open drain: only ever pulls low
   assign link.sda_d_o = 1'b0;
   assign link.sda_d_oe_n = sda_oe_n;

   // The serial clock idles between frames, so link flops clear
   // without it; only constants are loaded under reset.

   // start: data falls while clock high
   always_ff @(negedge link.sda or posedge sys_rst) begin
      if (sys_rst) begin
         start_tgl <= 1'b0;
      end else if (link.scl) begin
         start_tgl <= ~start_tgl;
      end
   end

   // stop: data rises while clock high
   always_ff @(posedge link.sda or posedge sys_rst) begin
      if (sys_rst) begin
         stop_tgl <= 1'b0;
      end else if (link.scl) begin
         stop_tgl <= ~stop_tgl;
      end
   end

   always_ff @(posedge link.scl or posedge sys_rst) begin
      if (sys_rst) begin
         sda_smp <= 1'b1;
      end else begin
         sda_smp <= link.sda;
      end
   end

   // Address-select straps, synchronised to the falling edge
   always_ff @(negedge link.scl or posedge sys_rst) begin
      if (sys_rst) begin
         sel_s <= 2'b00;
         en_s <= 2'b00;
      end else begin
         sel_s <= {sel_s[0], addr_sel};
         en_s <= {en_s[0], addr_sel_en};
      end
   end

   assign byte_in = {rx[6:0], sda_smp};

   assign own_hit = (byte_in[7:1] == stw_slave_addr(en_s[1] & sel_s[1]));

   // Every drive change happens on the falling clock, so the line
   // only moves while the clock is low and never fakes a start.
   always_ff @(negedge link.scl or posedge sys_rst) begin
      if (sys_rst) begin
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
         st <= DS_IDLE;
         bitn <= 4'h0;
         rx <= 8'h00;
         tx <= 8'hff;
         sda_oe_n <= 1'b1;
         rd_addr <= PTR_RST;
         wr_tgl <= 1'b0;
         wr_addr_l <= PTR_RST;
         wr_data_l <= 8'h00;
      end else if (start_tgl != start_seen) begin
         // any start, repeated or not, opens an address byte
         start_seen <= start_tgl;
         stop_seen <= stop_tgl;
         st <= DS_ADDR;
         bitn <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (stop_tgl != stop_seen) begin
         stop_seen <= stop_tgl;
         st <= DS_IDLE;
         sda_oe_n <= 1'b1;
      end else if (st != DS_IDLE) begin
         if (bitn < LAST_BIT) begin
            bitn <= bitn + 4'h1;
            rx <= byte_in;
            tx <= {tx[6:0], 1'b1};
            sda_oe_n <= (st == DS_RDATA) ? tx[6] : 1'b1;
         end else if (bitn == LAST_BIT) begin
            bitn <= ACK_SLOT;
            rx <= byte_in;
            sda_oe_n <= 1'b0;
            case (st)
               DS_ADDR: begin
                  if (!own_hit) begin
                     st <= DS_IDLE;
                     sda_oe_n <= 1'b1;
                  end else if (byte_in[0] == RW_READ) begin
                     st <= DS_RDATA;
                  end else begin
                     st <= DS_AHI;
                  end
               end
               DS_AHI: begin
                  rd_addr[15:8] <= byte_in;
                  st <= DS_ALO;
               end
               DS_ALO: begin
                  rd_addr[7:0] <= byte_in;
                  st <= DS_WDATA;
               end
               DS_WDATA: begin
                  wr_addr_l <= rd_addr;
                  wr_data_l <= byte_in;
                  wr_tgl <= ~wr_tgl;
                  rd_addr <= rd_addr + 16'h0001;
               end
               default: begin
                  // pointer advances; line freed for master
                  rd_addr <= rd_addr + 16'h0001;
                  sda_oe_n <= 1'b1;
               end
            endcase
         end else begin
            bitn <= 4'h0;
            sda_oe_n <= 1'b1;
            if (st == DS_RDATA) begin
               if (!sda_smp) begin
                  tx <= rd_data;
                  sda_oe_n <= rd_data[7];
               end else begin
                  st <= DS_IDLE;
               end
            end
         end
      end
   end

   // Write event crosses by toggle; address and data stay held for
   // a whole byte frame, far longer than the synchroniser delay.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_s <= 3'b000;
      end else begin
         wr_s <= {wr_s[1:0], wr_tgl};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_wr <= 1'b0;
         reg_waddr <= PTR_RST;
         reg_wdata <= 8'h00;
      end else begin
         reg_wr <= wr_s[2] ^ wr_s[1];
         if (wr_s[2] ^ wr_s[1]) begin
            reg_waddr <= wr_addr_l;
            reg_wdata <= wr_data_l;
         end
      end
   end

endmodule // stw_dev
`default_nettype wire

// ---- sim/stw_properties.sv ----
// Wire-level checks on the link between the master end and the sensor end.
// Instantiated beside the link interface; sees its resolved lines and both sda enables.
`timescale 1ns/10ps
`default_nettype none
module stw_properties
   import stw_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_oe_n,
   input wire logic sda_d_oe_n
);
   logic scl_q, sda_q, quiet, rise, start, stop, rd_phase;
   logic [3:0] bitn;
   logic [1:0] frame;
   logic [6:0] shreg;
   logic [7:0] abyte;
   logic [15:0] hcnt;

   assign rise = scl && !scl_q;
   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   assign rd_phase = (frame != 2'h0) && abyte[0] && !quiet;

   always_ff @(posedge clk_sys) begin
      scl_q <= sys_rst | scl;
      sda_q <= sys_rst | sda;
   end

   // Bit slot within a frame, frame count since the last start
   always_ff @(posedge clk_sys) begin
      if (sys_rst || start) begin
         bitn <= 4'h0;
         frame <= 2'h0;
      end else if (rise) begin
         shreg <= {shreg[5:0], sda};
         bitn <= (bitn == ACK_SLOT) ? 4'h0 : bitn + 4'h1;
         if (bitn == LAST_BIT && frame == 2'h0) begin
            abyte <= {shreg, sda};
         end
         if (bitn == ACK_SLOT && frame != 2'h3) begin
            frame <= frame + 2'h1;
         end
      end
   end

   // Set by an unanswered address or a refused read byte
   always_ff @(posedge clk_sys) begin
      if (sys_rst || start) begin
         quiet <= 1'b0;
      end else if (rise && bitn == ACK_SLOT && sda &&
                   (frame == 2'h0 || rd_phase)) begin
         quiet <= 1'b1;
      end
   end

   // High time counted from the rise, or from a start
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !scl) begin
         hcnt <= 16'h0000;
      end else if (start) begin
         hcnt <= 16'h0001;
      end else begin
         hcnt <= hcnt + 16'h0001;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_dev_edge_low:
   assert property ($changed(sda_d_oe_n) |-> !scl)
      else $error("sensor end changed sda while scl high");
   a_scl_high_time:
   assert property ($fell(scl) |-> hcnt >= 16'(QTR_CYC))
      else $error("scl high period too short");
   a_ack_master_rel:
   assert property (rise && bitn == ACK_SLOT && !rd_phase |-> sda_m_oe_n)
      else $error("master drove sda in a write ack slot");
   a_rd_master_rel:
   assert property (rise && bitn != ACK_SLOT && rd_phase |-> sda_m_oe_n)
      else $error("master drove sda during read data");
   a_rd_ack_dev_rel:
   assert property (rise && bitn == ACK_SLOT && rd_phase |-> sda_d_oe_n)
      else $error("sensor end drove sda in a read ack slot");
   a_wr_byte_ack:
   assert property (rise && bitn == ACK_SLOT && frame != 2'h0 && !abyte[0]
                    && !quiet |-> !sda_d_oe_n)
      else $error("write byte not acknowledged");
   a_addr_ack_drive:
   assert property (rise && bitn == ACK_SLOT && frame == 2'h0 && !sda
                    |-> !sda_d_oe_n)
      else $error("address acknowledge not from sensor end");
   a_quiet_release:
   assert property (quiet |-> sda_d_oe_n)
      else $error("sensor end drove sda after no-acknowledge");
   a_stop_idle:
   assert property (stop |-> sda_d_oe_n [*8])
      else $error("sensor end drove sda after stop");
endmodule // stw_properties
`default_nettype wire

// ---- sim/test_sensor_two_wire_register_port.sv ----
// Self-checking bench: master end and sensor end joined by the link.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_sensor_two_wire_register_port;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b0;
   logic cmd_go = 1'b0, cmd_rd = 1'b0, cmd_cur = 1'b0, cmd_alt = 1'b0;
   logic addr_sel_en = 1'b0, addr_sel = 1'b0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_len = 8'h01, wr_data = 8'h00;
   logic wr_take, rd_valid, busy, nack, reg_wr;
   logic [7:0] m_rd_data, d_rd_data, reg_wdata;
   logic [15:0] rd_addr, reg_waddr, a, b, c;
   logic [7:0] wbytes [4];
   logic [24:0] expq [$];
   integer seed = 32'h2068_a5d3;
   int widx = 0;
   int fails = 0;
   int checks = 0;

   stw_if link_if ();
   stw_master stw_master_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .link(link_if), .cmd_go(cmd_go), .cmd_rd(cmd_rd), .cmd_cur(cmd_cur),
      .cmd_alt(cmd_alt), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .wr_data(wr_data), .wr_take(wr_take), .rd_data(m_rd_data),
      .rd_valid(rd_valid), .busy(busy), .nack(nack));
   stw_dev stw_dev_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .link(link_if), .addr_sel_en(addr_sel_en), .addr_sel(addr_sel),
      .rd_addr(rd_addr), .rd_data(d_rd_data), .reg_wr(reg_wr),
      .reg_waddr(reg_waddr), .reg_wdata(reg_wdata));
   stw_properties stw_properties_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .scl(link_if.scl), .sda(link_if.sda),
      .sda_m_oe_n(link_if.sda_m_oe_n), .sda_d_oe_n(link_if.sda_d_oe_n));

   always #25 clk_sys = ~clk_sys;

   // Register file stand-in: value is a fixed mix of its address
   function automatic logic [7:0] rd_val(input logic [15:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h5a;
   endfunction
   assign d_rd_data = rd_val(rd_addr);

   task automatic cmp(input string what, input logic [24:0] exp,
                      input logic [24:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      if (expq.size() != 0) begin
         fails++;
         $display("MISMATCH pending_notes expected 0 seen %0d", expq.size());
      end
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Next write byte is ready before the master samples it
   always @(posedge clk_sys) begin
      if (wr_take === 1'b1) begin
         widx <= widx + 1;
         wr_data <= wbytes[(widx + 1) % 4];
      end
   end

   // Oldest note against each result as it appears
   always @(negedge clk_sys) begin
      if (reg_wr === 1'b1) begin
         if (expq.size() == 0) begin
            cmp("reg_write", 25'h1ff_ffff, {1'b0, reg_waddr, reg_wdata});
         end else begin
            cmp("reg_write", expq.pop_front(), {1'b0, reg_waddr, reg_wdata});
         end
      end
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) begin
            cmp("read_byte", 25'h0ff_ffff, {1'b1, 16'h0000, m_rd_data});
         end else begin
            cmp("read_byte", expq.pop_front(), {1'b1, 16'h0000, m_rd_data});
         end
      end
   end

   // Called just after a rising edge; returns just after one
   task automatic run_cmd(input logic rd, cur, alt, input logic [15:0] adr,
                          input logic [7:0] len, input logic exp_nack);
      int n;
      widx = 0;
      cmd_rd <= rd;
      cmd_cur <= cur;
      cmd_alt <= alt;
      cmd_addr <= adr;
      cmd_len <= len;
      wr_data <= wbytes[0];
      cmd_go <= 1'b1;
      @(posedge clk_sys);
      cmd_go <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (busy !== 1'b0 && n < 40000);
      if (n >= 40000) begin
         fails++;
         $display("MISMATCH busy expected 0 seen %b", busy);
         summarize();
      end
      cmp("nack", {24'h00_0000, exp_nack}, {24'h00_0000, nack});
      @(posedge clk_sys);
   endtask

   initial begin
      // A real rising edge: link-side flops reset only on it
      sys_rst <= 1'b1;
      a = 16'($random(seed));
      b = 16'($random(seed));
      c = 16'($random(seed));
      for (int i = 0; i < 4; i++) begin
         wbytes[i] = 8'($random(seed));
      end
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 2; i++) begin
         expq.push_back({1'b0, a + 16'(i), wbytes[i]});
      end
      run_cmd(1'b0, 1'b0, 1'b0, a, 8'h02, 1'b0);
      expq.push_back({1'b1, 16'h0000, rd_val(a + 16'h0002)});
      run_cmd(1'b0, 1'b1, 1'b0, 16'h0000, 8'h01, 1'b0);
      for (int i = 0; i < 4; i++) begin
         expq.push_back({1'b1, 16'h0000, rd_val(b + 16'(i))});
      end
      run_cmd(1'b1, 1'b0, 1'b0, b, 8'h02, 1'b0);
      run_cmd(1'b0, 1'b1, 1'b0, 16'h0000, 8'h02, 1'b0);
      // Alternate address while not selected is ignored
      run_cmd(1'b0, 1'b0, 1'b1, c, 8'h01, 1'b1);
      addr_sel_en <= 1'b1;
      addr_sel <= 1'b1;
      expq.push_back({1'b0, c, wbytes[0]});
      run_cmd(1'b0, 1'b0, 1'b1, c, 8'h01, 1'b0);
      run_cmd(1'b0, 1'b0, 1'b0, c, 8'h01, 1'b1);
      // Select without enable keeps the default address
      addr_sel_en <= 1'b0;
      run_cmd(1'b0, 1'b0, 1'b1, c, 8'h01, 1'b1);
      repeat (4) @(posedge clk_sys);
      summarize();
   end
endmodule // test_sensor_two_wire_register_port
`default_nettype wire
